/* logic/eeprom_front_pkg.sv */
// Purpose: shared constants and carriers for the two-wire memory front end
// Assumes: core clock of 125 MHz, two-wire lines sampled by that clock
// Notes:   timing counts are derived from printed times
package eeprom_front_pkg;

    // ==========================================================
    // Clock rate and sizes
    localparam int CLK_MHZ       = 125;
    localparam int BYTE_W        = 8;
    localparam int WORD_ADDR_W   = 7;
    localparam int CS_W          = 3;
    localparam int CODE_W        = 4;
    localparam int PAGE_DEPTH    = 16;
    localparam int PAGE_IDX_W    = 4;
    localparam int PAGE_CNT_W    = 5;
    localparam int BIT_CNT_W     = 3;
    localparam int TIMER_W       = 20;

    // ==========================================================
    // Control byte fields
    localparam int CODE_MSB      = 7;
    localparam int CODE_LSB      = 4;
    localparam int CS_MSB        = 3;
    localparam int CS_LSB        = 1;
    localparam int RW_POS        = 0;
    localparam logic RW_READ     = 1'b1;
    localparam logic RW_WRITE    = 1'b0;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;

    // ==========================================================
    // Timing
    localparam int WC_TIME_US    = 5000;
    localparam int WC_CYCLES     = WC_TIME_US * CLK_MHZ;

    // ==========================================================
    // Reset values and page count limit
    localparam logic [BYTE_W-1:0]      SHIFT_RST = 8'h00;
    localparam logic [WORD_ADDR_W-1:0] ADDR_RST  = 7'h00;
    localparam logic [CS_W-1:0]        CS_RST    = 3'h0;
    localparam logic [PAGE_CNT_W-1:0]  CNT_RST   = 5'h00;
    localparam logic [TIMER_W-1:0]     TIMER_RST = 20'h00000;
    localparam logic [PAGE_CNT_W-1:0]  CNT_FULL  = 5'h10;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic            scl;
        logic            sda;
        logic            wp;
        logic [CS_W-1:0] cs;
    } pins_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
    } line_evt_t;

    typedef struct packed {
        logic                          go;
        logic                          we;
        logic [CS_W+WORD_ADDR_W-1:0]   addr;
        logic [PAGE_CNT_W-1:0]         count;
    } commit_t;

endpackage

/* logic/line_watch.sv */
// Purpose: synchronise bus pins and find clock edges, start and stop
// Assumes: pins are asynchronous to core_clk
// Notes:   first sync stage feeds only the second stage
`timescale 1ns/1ps
module line_watch
    import eeprom_front_pkg::*;
(
    input  wire logic      core_clk,
    input  wire logic      sys_rst,
    input  wire pins_t     pins_async,
    output pins_t          pins_sync,
    output line_evt_t      evt
);

    // ==========================================================
    // Two-flop synchronisers, one per pin bit
    localparam int PW = $bits(pins_t);
    logic [PW-1:0] meta_reg;
    logic [PW-1:0] sync_reg;
    logic [PW-1:0] prev_reg;

    genvar gi;
    generate
        for (gi = 0; gi < PW; gi++) begin : g_sync
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    meta_reg[gi] <= 1'b1;
                    sync_reg[gi] <= 1'b1;
                    prev_reg[gi] <= 1'b1;
                end else begin
                    meta_reg[gi] <= pins_async[gi];
                    sync_reg[gi] <= meta_reg[gi];
                    prev_reg[gi] <= sync_reg[gi];
                end
            end
        end
    endgenerate

    pins_t cur;
    pins_t old;
    assign cur       = pins_t'(sync_reg);
    assign old       = pins_t'(prev_reg);
    assign pins_sync = cur;

    // ==========================================================
    // Edge and framing events, one cycle each
    always_comb begin
        evt.scl_rise = cur.scl & ~old.scl;
        evt.scl_fall = ~cur.scl & old.scl;
        evt.start    = cur.scl & old.scl & old.sda & ~cur.sda;
        evt.stop     = cur.scl & old.scl & ~old.sda & cur.sda;
    end

endmodule

/* logic/page_buffer.sv */
// Purpose: page buffer holding the latest received write bytes
// Assumes: one write and one registered read per cycle
// Notes:   index wraps, so newer bytes displace the oldest
`timescale 1ns/1ps
module page_buffer
    import eeprom_front_pkg::*;
#(
    parameter int DEPTH = PAGE_DEPTH,
    parameter int W     = BYTE_W
)(
    input  wire logic                     core_clk,
    input  wire logic                     sys_rst,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input  wire logic [W-1:0]             wr_data,
    input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic      [W-1:0]             rd_data
);

    // ==========================================================
    // Storage
    logic [W-1:0] mem [DEPTH];
    logic [W-1:0] rd_data_next;

    always_comb begin
        rd_data_next = mem[rd_idx];
    end

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
        if (sys_rst) begin
            rd_data <= '0;
        end else begin
            rd_data <= rd_data_next;
        end
    end

endmodule

/* logic/eeprom_two_wire_slave_front.sv */
// Purpose: two-wire slave front end of a small serial memory
// Assumes: master drives the clock; memory array logic sits outside
// Notes:   data line is open drain, only pulled low here
//
// Function
// - Selected only when all three chip address pins match received select bits.
// - Data line is only pulled low or released, never driven high.
// - Data changes only while the serial clock is low, except framing.
// - Write-protect high inhibits memory writes; reads still served.
// - Data falling while clock high is a start; commands begin with one.
// - Data rising while clock high is a stop; operations end with one.
// - One bit per clock pulse, sampled while clock is high.
// - Any byte count accepted; only the latest sixteen write bytes kept.
// - Receiver acknowledges each byte on an extra ninth clock pulse.
// - No acknowledge at all while internal programming runs.
// - Acknowledge holds data low through the whole ack clock high time.
// - Master ends a read by not acknowledging; slave releases the line.
// - First byte after start is control: type code then select bits.
// - Select bits form the address bits above the word address.
// - Last control bit set means read, clear means write.
// - Acknowledge control byte only on code and select match.
// - Each write data byte increments only the low four address bits.
// - Stop ending a write launches the timed internal write cycle.
`timescale 1ns/1ps
module eeprom_two_wire_slave_front
    import eeprom_front_pkg::*;
#(
    parameter logic [CODE_W-1:0] DEV_CODE    = 4'h5,      // Arbitrary value
    parameter int                WRITE_CYCLES = WC_CYCLES
)(
    input  wire logic                         core_clk,
    input  wire logic                         sys_rst,
    input  wire logic                         scl_in,
    input  wire logic                         sda_in,
    output logic                              sda_out,
    output logic                              sda_oe,
    input  wire logic                         chip_select_pin_low,
    input  wire logic                         chip_select_pin_mid,
    input  wire logic                         chip_select_pin_high,
    input  wire logic                         write_protect,
    input  wire logic [BYTE_W-1:0]            tx_data,
    output logic      [CS_W+WORD_ADDR_W-1:0]  rd_addr,
    output logic                              rd_fetch,
    input  wire logic [PAGE_IDX_W-1:0]        page_rd_idx,
    output logic      [BYTE_W-1:0]            page_rd_data,
    output logic                              prog_busy,
    output commit_t                           commit
);

    // ==========================================================
    // Pin conditioning
    pins_t     pins_async;
    pins_t     pins;
    line_evt_t evt;

    assign pins_async = '{scl: scl_in, sda: sda_in, wp: write_protect,
                          cs: {chip_select_pin_high, chip_select_pin_mid,
                               chip_select_pin_low}};

    line_watch u_line_watch (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .pins_async (pins_async),
        .pins_sync  (pins),
        .evt        (evt)
    );

    // ==========================================================
    // State
    typedef enum logic [3:0] {
        ST_IDLE, ST_CTRL, ST_CTRL_ACK, ST_ADDR, ST_ADDR_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_TX, ST_TX_ACK, ST_IGNORE
    } state_t;

    state_t                        state_reg,   state_next;
    logic [BYTE_W-1:0]             shift_reg,   shift_next;
    logic [BIT_CNT_W-1:0]          bit_reg,     bit_next;
    logic                          full_reg,    full_next;
    logic                          rw_reg,      rw_next;
    logic [CS_W-1:0]               cs_reg,      cs_next;
    logic [WORD_ADDR_W-1:0]        addr_reg,    addr_next;
    logic [WORD_ADDR_W-1:0]        base_reg,    base_next;
    logic [PAGE_CNT_W-1:0]         cnt_reg,     cnt_next;
    logic                          oe_reg,      oe_next;
    logic                          mack_reg,    mack_next;
    logic [TIMER_W-1:0]            timer_reg,   timer_next;
    logic                          busy_reg,    busy_next;
    logic                          fetch_reg,   fetch_next;
    commit_t                       commit_reg,  commit_next;
    logic                          buf_we;
    logic                          ctrl_match;
    logic                          in_write;

    // Open drain: the output level is always low, only the enable moves
    assign sda_out      = 1'b0;
    assign sda_oe       = oe_reg;
    assign prog_busy    = busy_reg;
    assign rd_fetch     = fetch_reg;
    assign rd_addr      = {cs_reg, addr_reg};
    assign commit       = commit_reg;

    // ==========================================================
    // Page buffer
    page_buffer #(
        .DEPTH (PAGE_DEPTH),
        .W     (BYTE_W)
    ) u_page_buffer (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .wr_en    (buf_we),
        .wr_idx   (addr_reg[PAGE_IDX_W-1:0]),
        .wr_data  (shift_reg),
        .rd_idx   (page_rd_idx),
        .rd_data  (page_rd_data)
    );

    // Code and every select bit must agree
    assign ctrl_match = (shift_reg[CODE_MSB:CODE_LSB] == DEV_CODE) &&
                        (shift_reg[CS_MSB:CS_LSB] == pins.cs);
    assign in_write   = (state_reg == ST_WDATA) || (state_reg == ST_WDATA_ACK);

    // ==========================================================
    // Next state
    always_comb begin
        state_next  = state_reg;
        shift_next  = shift_reg;
        bit_next    = bit_reg;
        full_next   = full_reg;
        rw_next     = rw_reg;
        cs_next     = cs_reg;
        addr_next   = addr_reg;
        base_next   = base_reg;
        cnt_next    = cnt_reg;
        oe_next     = oe_reg;
        mack_next   = mack_reg;
        timer_next  = timer_reg;
        busy_next   = busy_reg;
        fetch_next  = 1'b0;
        commit_next = commit_reg;
        commit_next.go = 1'b0;
        buf_we      = 1'b0;

        // Self-timed programming cycle
        if (busy_reg) begin
            if (timer_reg == TIMER_RST) begin
                busy_next = 1'b0;
            end else begin
                timer_next = timer_reg - 20'h00001;
            end
        end

        // Receive sampling while clock high
        if (evt.scl_rise) begin
            if (state_reg == ST_CTRL || state_reg == ST_ADDR ||
                state_reg == ST_WDATA) begin
                shift_next = {shift_reg[BYTE_W-2:0], pins.sda};
                bit_next   = bit_reg + 3'h1;
                full_next  = (bit_reg == LAST_BIT);
            end
            if (state_reg == ST_TX_ACK) begin
                mack_next = ~pins.sda;
            end
        end

        if (evt.stop) begin
            state_next = ST_IDLE;
            oe_next    = 1'b0;
            // Stop also unblocks a device left ignoring the bus
            if (in_write && cnt_reg != CNT_RST) begin
                busy_next          = 1'b1;
                timer_next         = TIMER_W'(WRITE_CYCLES - 1);
                commit_next.go     = 1'b1;
                commit_next.we     = ~pins.wp;
                commit_next.addr   = {cs_reg, base_reg};
                commit_next.count  = cnt_reg;
            end
        end else if (evt.start) begin
            state_next = ST_CTRL;
            bit_next   = '0;
            full_next  = 1'b0;
            oe_next    = 1'b0;
        end else if (evt.scl_fall) begin
            // Drive changes other than the release at start or stop happen here, with the clock low
            case (state_reg)
                ST_CTRL: begin
                    if (full_reg) begin
                        full_next = 1'b0;
                        if (ctrl_match && !busy_reg) begin
                            oe_next    = 1'b1;
                            rw_next    = shift_reg[RW_POS];
                            cs_next    = shift_reg[CS_MSB:CS_LSB];
                            state_next = ST_CTRL_ACK;
                        end else begin
                            state_next = ST_IGNORE;
                        end
                    end
                end
                ST_CTRL_ACK: begin
                    bit_next = '0;
                    if (rw_reg == RW_READ) begin
                        shift_next = tx_data;
                        oe_next    = ~tx_data[BYTE_W-1];
                        fetch_next = 1'b1;
                        addr_next  = addr_reg + 7'h01;
                        state_next = ST_TX;
                    end else begin
                        oe_next    = 1'b0;
                        state_next = ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    if (full_reg) begin
                        full_next  = 1'b0;
                        addr_next  = shift_reg[WORD_ADDR_W-1:0];
                        base_next  = shift_reg[WORD_ADDR_W-1:0];
                        cnt_next   = CNT_RST;
                        oe_next    = 1'b1;
                        state_next = ST_ADDR_ACK;
                    end
                end
                ST_ADDR_ACK: begin
                    oe_next    = 1'b0;
                    state_next = ST_WDATA;
                end
                ST_WDATA: begin
                    if (full_reg) begin
                        full_next  = 1'b0;
                        buf_we     = 1'b1;
                        addr_next  = {addr_reg[WORD_ADDR_W-1:PAGE_IDX_W],
                                      addr_reg[PAGE_IDX_W-1:0] + 4'h1};
                        if (cnt_reg != CNT_FULL) begin
                            cnt_next = cnt_reg + 5'h01;
                        end
                        oe_next    = 1'b1;
                        state_next = ST_WDATA_ACK;
                    end
                end
                ST_WDATA_ACK: begin
                    oe_next    = 1'b0;
                    state_next = ST_WDATA;
                end
                ST_TX: begin
                    if (bit_reg == LAST_BIT) begin
                        oe_next    = 1'b0;
                        mack_next  = 1'b0;
                        state_next = ST_TX_ACK;
                    end else begin
                        shift_next = {shift_reg[BYTE_W-2:0], 1'b0};
                        oe_next    = ~shift_reg[BYTE_W-2];
                        bit_next   = bit_reg + 3'h1;
                    end
                end
                ST_TX_ACK: begin
                    bit_next = '0;
                    if (mack_reg) begin
                        shift_next = tx_data;
                        oe_next    = ~tx_data[BYTE_W-1];
                        fetch_next = 1'b1;
                        addr_next  = addr_reg + 7'h01;
                        state_next = ST_TX;
                    end else begin
                        oe_next    = 1'b0;
                        state_next = ST_IGNORE;
                    end
                end
                default: begin
                    oe_next = 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg  <= ST_IDLE;
            shift_reg  <= SHIFT_RST;
            bit_reg    <= '0;
            full_reg   <= 1'b0;
            rw_reg     <= RW_WRITE;
            cs_reg     <= CS_RST;
            addr_reg   <= ADDR_RST;
            base_reg   <= ADDR_RST;
            cnt_reg    <= CNT_RST;
            oe_reg     <= 1'b0;
            mack_reg   <= 1'b0;
            timer_reg  <= TIMER_RST;
            busy_reg   <= 1'b0;
            fetch_reg  <= 1'b0;
            commit_reg <= '0;
        end else begin
            state_reg  <= state_next;
            shift_reg  <= shift_next;
            bit_reg    <= bit_next;
            full_reg   <= full_next;
            rw_reg     <= rw_next;
            cs_reg     <= cs_next;
            addr_reg   <= addr_next;
            base_reg   <= base_next;
            cnt_reg    <= cnt_next;
            oe_reg     <= oe_next;
            mack_reg   <= mack_next;
            timer_reg  <= timer_next;
            busy_reg   <= busy_next;
            fetch_reg  <= fetch_next;
            commit_reg <= commit_next;
        end
    end

endmodule

/* tb/eeprom_front_asserts.sv */
// Purpose: port-level protocol checks for the memory front end
// Assumes: link half period of several core cycles
// Notes:   bound from the bench top file
`timescale 1ns/1ps
module eeprom_front_asserts
    import eeprom_front_pkg::*;
#(
    parameter int WRITE_CYCLES = WC_CYCLES
)(
    input wire logic                        core_clk,
    input wire logic                        sys_rst,
    input wire logic                        scl_in,
    input wire logic                        sda_in,
    input wire logic                        sda_out,
    input wire logic                        sda_oe,
    input wire logic                        chip_select_pin_low,
    input wire logic                        chip_select_pin_mid,
    input wire logic                        chip_select_pin_high,
    input wire logic                        write_protect,
    input wire logic [BYTE_W-1:0]           tx_data,
    input wire logic [CS_W+WORD_ADDR_W-1:0] rd_addr,
    input wire logic                        rd_fetch,
    input wire logic [PAGE_IDX_W-1:0]       page_rd_idx,
    input wire logic [BYTE_W-1:0]           page_rd_data,
    input wire logic                        prog_busy,
    input wire commit_t                     commit
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // ==========================================================
    // Busy length counter
    int busy_cnt_reg;
    int busy_cnt_next;
    always_comb busy_cnt_next = prog_busy ? busy_cnt_reg + 1 : 0;
    always_ff @(posedge core_clk) busy_cnt_reg <= sys_rst ? 0 : busy_cnt_next;

    // ==========================================================
    // Properties
    property p_open_drain; sda_oe |-> sda_out == 1'b0; endproperty
    property p_oe_scl_low; $changed(sda_oe) |-> !scl_in; endproperty
    property p_no_ack_busy; $rose(sda_oe) |-> !prog_busy; endproperty
    property p_ack_hold; $rose(scl_in) && sda_oe |-> sda_oe [*5]; endproperty
    property p_go_pulse; commit.go |=> !commit.go; endproperty
    property p_go_busy; commit.go |-> ##[0:1] prog_busy; endproperty
    property p_count; commit.go |-> commit.count inside {[5'h01:5'h10]}; endproperty
    property p_busy_len; $fell(prog_busy) |-> busy_cnt_reg == WRITE_CYCLES; endproperty
    property p_wp;
        commit.go && $past(write_protect, 8) == write_protect
            |-> commit.we == !write_protect;
    endproperty
    property p_addr_sel;
        rd_fetch |-> rd_addr[9:7] == {chip_select_pin_high, chip_select_pin_mid,
                                      chip_select_pin_low};
    endproperty

    a_open_drain: assert property (p_open_drain) else $error("data driven high");
    a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved, clk high");
    a_no_ack_busy: assert property (p_no_ack_busy) else $error("ack while busy");
    a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
    a_go_pulse: assert property (p_go_pulse) else $error("commit too long");
    a_go_busy: assert property (p_go_busy) else $error("busy not raised");
    a_count: assert property (p_count) else $error("count out of range");
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    a_wp: assert property (p_wp) else $error("write enable vs protect");
    a_addr_sel: assert property (p_addr_sel) else $error("select bits wrong");

    c_full_page: cover property (commit.go && commit.count == 5'h10);
    c_fetch: cover property (rd_fetch);
    c_ack: cover property ($rose(sda_oe));
endmodule

/* tb/two_wire_master.sv */
// Purpose: two-wire bus master that frames every transfer
// Assumes: data wire resolved with a pull-up in the bench
// Notes:   half period 4 core cycles; the ack moves 3 cycles after a fall
`timescale 1ns/1ps
module two_wire_master #(
    parameter int HALF = 4
)(
    input  wire logic core_clk,
    output logic      scl,
    output logic      sda_rel,
    input  wire logic sda_wire
);
    // Clock stands high between frames
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end

    task automatic hold();
        repeat (HALF) @(posedge core_clk);
    endtask

    task automatic start();
        @(posedge core_clk);
        sda_rel <= 1'b1;
        hold();
        scl <= 1'b1;
        hold();
        sda_rel <= 1'b0;
        hold();
        scl <= 1'b0;
    endtask

    task automatic stop();
        @(posedge core_clk);
        sda_rel <= 1'b0;
        hold();
        scl <= 1'b1;
        hold();
        sda_rel <= 1'b1;
        hold();
    endtask

    task automatic put_bit(input logic b, output logic s);
        @(posedge core_clk);
        sda_rel <= b;
        repeat (HALF - 1) @(posedge core_clk);
        scl <= 1'b1;
        hold();
        s = sda_wire;
        scl <= 1'b0;
    endtask

    // Ninth bit carries the ack either way
    task automatic xbyte(input logic [7:0] d, input logic mack,
                         output logic [7:0] r, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(d[i], r[i]);
        put_bit(mack, s);
        ack = !s;
    endtask
endmodule

/* tb/eeprom_two_wire_slave_front_tb_top.sv */
// Purpose: self-checking bench for the two-wire memory front end
// Assumes: short write cycle parameter
// Notes:   random data from a fixed seed
`timescale 1ns/1ps
module eeprom_two_wire_slave_front_tb_top
    import eeprom_front_pkg::*;
;
    localparam logic [3:0] DEV = 4'h6; // Arbitrary code value
    localparam int         WC  = 400;
    logic       core_clk, sys_rst, write_protect, sda_out, sda_oe;
    logic       rd_fetch, prog_busy, scl, sda_rel, go_seen, ack;
    logic [2:0] cs_pins, cs;
    logic [3:0] page_rd_idx;
    logic [6:0] base;
    logic [7:0] tx_data, page_rd_data, r, d;
    logic [7:0] data [0:31];
    logic [9:0] rd_addr;
    commit_t    commit, go_cap;
    int         error_cnt, tests_run, seed, n, k;
    wire        sda_wire = sda_rel & !(sda_oe & !sda_out);

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    eeprom_two_wire_slave_front #(.DEV_CODE(DEV), .WRITE_CYCLES(WC)) uut (
        .core_clk, .sys_rst, .scl_in(scl), .sda_in(sda_wire), .sda_out, .sda_oe,
        .chip_select_pin_low(cs_pins[0]), .chip_select_pin_mid(cs_pins[1]),
        .chip_select_pin_high(cs_pins[2]), .write_protect, .tx_data, .rd_addr,
        .rd_fetch, .page_rd_idx, .page_rd_data, .prog_busy, .commit);
    two_wire_master #(.HALF(4)) mst (.core_clk, .scl, .sda_rel, .sda_wire);

    always @(posedge core_clk) if (commit.go === 1'b1) begin
        go_seen <= 1'b1;
        go_cap <= commit;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic summarize();
        if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    function automatic logic [7:0] ctl(input logic [3:0] c, input logic [2:0] s,
                                       input logic rw);
        return {c, s, rw};
    endfunction

    task automatic wait_idle();
        for (int i = 0; i < WC + 100 && prog_busy !== 1'b0; i++) @(posedge core_clk);
        chk("busy_end", 0, prog_busy);
        if (prog_busy !== 1'b0) summarize();
    endtask

    initial begin
        seed = 75078;
        error_cnt = 0;
        tests_run = 0;
        sys_rst = 1'b1;
        write_protect = 1'b0;
        cs_pins = 3'h0;
        tx_data = 8'h00;
        page_rd_idx = 4'h0;
        go_seen = 1'b0;
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        for (int t = 0; t < 4; t++) begin
            cs = $random(seed) & {t[1], 2'h3};
            base = $random(seed);
            n = (t == 1) ? 18 : 1 + ($random(seed) & 15);
            cs_pins <= cs;
            write_protect <= t[0];
            repeat (8) @(posedge core_clk);
            // ==================================================
            // Page write, optionally after an aborted byte
            if (t == 3) begin
                mst.start();
                for (k = 0; k < 4; k++) mst.put_bit(DEV[3-k], r[k]);
            end
            mst.start();
            mst.xbyte(ctl(DEV, cs, RW_WRITE), 1'b1, r, ack);
            chk("ctl_ack", 1, ack);
            mst.xbyte({1'b0, base}, 1'b1, r, ack);
            chk("adr_ack", 1, ack);
            for (k = 0; k < n; k++) begin
                data[k] = $random(seed);
                mst.xbyte(data[k], 1'b1, r, ack);
                chk("dat_ack", 1, ack);
            end
            go_seen <= 1'b0;
            mst.stop();
            for (k = (n > 16 ? n - 16 : 0); k < n; k++) begin
                page_rd_idx <= base[3:0] + k[3:0];
                repeat (2) @(posedge core_clk);
                chk("page", data[k], page_rd_data);
            end
            chk("go", 1, go_seen);
            chk("we", !t[0], go_cap.we);
            chk("addr", {cs, base}, go_cap.addr);
            chk("count", n > 16 ? 16 : n, go_cap.count);
            chk("busy", 1, prog_busy);
            // ==================================================
            // Polling while busy, then mismatched control
            mst.start();
            mst.xbyte(ctl(DEV, cs, RW_WRITE), 1'b1, r, ack);
            chk("busy_ack", 0, ack);
            mst.stop();
            wait_idle();
            mst.start();
            mst.xbyte(ctl(t[0] ? DEV : DEV ^ 4'h1, t[0] ? cs ^ 3'h4 : cs, RW_WRITE),
                      1'b1, r, ack);
            chk("miss_ack", 0, ack);
            mst.xbyte(ctl(DEV, cs, RW_WRITE), 1'b1, r, ack);
            chk("ign_ack", 0, ack);
            // ==================================================
            // Read two bytes, end with no ack
            d = $random(seed);
            tx_data <= d;
            mst.start();
            mst.xbyte(ctl(DEV, cs, RW_READ), 1'b1, r, ack);
            chk("rd_ack", 1, ack);
            mst.xbyte(8'hff, 1'b0, r, ack);
            chk("rd_byte", d, r);
            mst.xbyte(8'hff, 1'b1, r, ack);
            chk("rd_byte2", d, r);
            repeat (6) @(posedge core_clk);
            chk("release", 1, sda_wire);
            chk("rd_addr", {cs, 7'({base[6:4], base[3:0] + n[3:0]} + 7'h02)}, rd_addr);
            mst.stop();
        end
        summarize();
    end
endmodule

bind eeprom_two_wire_slave_front eeprom_front_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
    .core_clk, .sys_rst, .scl_in, .sda_in, .sda_out, .sda_oe, .chip_select_pin_low,
    .chip_select_pin_mid, .chip_select_pin_high, .write_protect, .tx_data, .rd_addr,
    .rd_fetch, .page_rd_idx, .page_rd_data, .prog_busy, .commit);
